// ---- bench/tws_master.sv ----
/*
  Behavioural bus master for the two-wire register slave: start, stop,
  byte writes and byte reads, driven by delays at a 500 kHz bus clock.
  Assumes the bench builds the data wire with a pull-up from both pulls.
*/
`timescale 1ns/1ns
module tws_master (
  // Bus clock, owned by the master alone
  output logic scl,
  // Data pull, low pulls the wire down
  output logic sda_pull_n,
  // Data wire level
  input wire logic sda
);
  // ============================================================
  // Bus timing
  // Quarter bit of 500 ns keeps the bus clock well under a tenth of link_clk
  localparam int QTR = 500;

  // Idle bus at time zero, clock stands still between frames
  initial
  begin
    scl = 1'b1;
    sda_pull_n = 1'b1;
  end

  // ============================================================
  // Protocol elements
  // Start from idle, or a restart from the clock-low phase
  task automatic start();
    if (scl === 1'b0)
    begin
      sda_pull_n = 1'b1;
      #QTR;
      scl = 1'b1;
      #QTR;
    end
    sda_pull_n = 1'b0;
    #QTR;
    scl = 1'b0;
    #QTR;
  endtask

  // Stop, then the bus is left idle
  task automatic stop();
    sda_pull_n = 1'b0;
    #QTR;
    scl = 1'b1;
    #QTR;
    sda_pull_n = 1'b1;
    #QTR;
  endtask

  // Data only changes in the clock-low phase, pulled low or released
  task automatic put_bit(input logic b);
    sda_pull_n = b;
    #QTR;
    scl = 1'b1;
    #(2 * QTR);
    scl = 1'b0;
    #QTR;
  endtask

  // Released line, sampled in the middle of the high phase
  task automatic get_bit(output logic b);
    sda_pull_n = 1'b1;
    #QTR;
    scl = 1'b1;
    #QTR;
    b = sda;
    #QTR;
    scl = 1'b0;
    #QTR;
  endtask

  // Eight bits MSB first, then the slave's acknowledge
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      put_bit(b[i]);
    get_bit(s);
    ack = ~s;
  endtask

  // Eight bits in, then acknowledge to continue or not to end
  task automatic rd_byte(input logic ack, output logic [7:0] b);
    for (int i = 7; i >= 0; i--)
      get_bit(b[i]);
    put_bit(~ack);
  endtask
endmodule

// ---- bench/tws_slave_tb.sv ----
/*
  Self-checking bench of the two-wire register slave: a bus master model,
  a register port model with a write log, and one task per scenario.
  Assumes the register port answers from its own array or a fixed pattern.
*/
`timescale 1ns/1ns
module tws_slave_tb;
  import tws_pkg::*;
  // ============================================================
  // Signals
  logic ref_clk, sys_rst, link_clk, scl, mst_pull_n, sda_w, sel_en, sel;
  logic sdo, oe_n, wr, rd;
  logic [15:0] raddr;
  logic [7:0] wdata, rdata;
  logic [7:0] mem [logic [15:0]];
  tws_req_t wlog[$];
  int n_fail, compares, cyc;

  // Open-drain wire with pull-up
  assign sda_w = (mst_pull_n !== 1'b0) && !(oe_n === 1'b0 && sdo === 1'b0);

  tws_slave dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .link_clk(link_clk),
    .scl_in(scl), .serial_data_line_in(sda_w), .serial_data_line_out(sdo),
    .serial_data_line_oe_n(oe_n), .slave_addr_sel_en(sel_en), .slave_addr_sel(sel),
    .regp_addr_r(raddr), .regp_wdata_r(wdata), .regp_wr_r(wr), .regp_rd_r(rd),
    .regp_rdata(rdata));
  tws_master mst_u (.scl(scl), .sda_pull_n(mst_pull_n), .sda(sda_w));

  // ============================================================
  // Clocks, link clock unrelated in phase
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial
  begin
    link_clk = 1'b0;
    #17;
    forever #40 link_clk = ~link_clk;
  end

  // Unwritten registers read as a pattern so the addresses read here differ
  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction

  // Register port: data on the cycle after the read strobe, writes logged
  always @(posedge ref_clk)
  begin
    if (rd === 1'b1)
      rdata <= #1 mem.exists(raddr) ? mem[raddr] : pat(raddr);
    if (wr === 1'b1)
    begin
      mem[raddr] = wdata;
      wlog.push_back('{addr: raddr, wdata: wdata, wr: 1'b1});
    end
  end

  // ============================================================
  // Compare tasks and verdict
  task automatic chk1(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_of_test();
    if (n_fail == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Timeout, a run should take about 8800 cycles
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      chk1("timeout", 1'b0, 1'b1);
      end_of_test();
    end
  end

  // Slave moves data only while the clock is low, and only pulls low
  always @(oe_n)
    if (cyc > 40)
      chk1("data change at clock high", 1'b0, scl);
  always @(posedge link_clk)
    if (oe_n === 1'b0)
      chk1("driven level", 1'b0, sdo);

  // ============================================================
  // Byte helpers
  task automatic wb(input logic [7:0] b, input logic e, input string nm);
    logic a;
    mst_u.wr_byte(b, a);
    chk1(nm, e, a);
  endtask
  task automatic rb(input logic [7:0] e, input logic ack, input string nm);
    logic [7:0] d;
    mst_u.rd_byte(ack, d);
    chk8(nm, e, d);
  endtask
  task automatic settle();
    repeat (10) @(posedge ref_clk);
    #1;
  endtask

  // ============================================================
  // Scenarios
  // Two data bytes to consecutive registers
  task automatic t_write();
    wlog.delete();
    mst_u.start();
    wb(8'h20, 1'b1, "write addr ack");
    wb(8'h12, 1'b1, "ptr high ack");
    wb(8'h34, 1'b1, "ptr low ack");
    wb(8'hab, 1'b1, "data 0 ack");
    wb(8'hcd, 1'b1, "data 1 ack");
    mst_u.stop();
    settle();
    chk16("write count", 16'h0002, 16'(wlog.size()));
    chk16("write addr 0", 16'h1234, wlog[0].addr);
    chk8("write data 0", 8'hab, wlog[0].wdata);
    chk16("write addr 1", 16'h1235, wlog[1].addr);
    chk8("write data 1", 8'hcd, wlog[1].wdata);
  endtask

  // Pointer write, restart, two reads, then released after no-acknowledge
  task automatic t_rand_read();
    wlog.delete();
    mst_u.start();
    wb(8'h20, 1'b1, "dummy write ack");
    wb(8'h12, 1'b1, "rd ptr high ack");
    wb(8'h34, 1'b1, "rd ptr low ack");
    mst_u.start();
    wb(8'h21, 1'b1, "read addr ack");
    rb(8'hab, 1'b1, "random read 0");
    rb(8'hcd, 1'b0, "random read 1");
    chk1("released after nack", 1'b1, oe_n);
    mst_u.stop();
    settle();
    chk16("pointer only writes", 16'h0000, 16'(wlog.size()));
  endtask

  // Reads from the current pointer, two independent sequences
  task automatic t_cur_read();
    mst_u.start();
    wb(8'h21, 1'b1, "cur read ack");
    rb(pat(16'h1236), 1'b1, "cur read 0");
    rb(pat(16'h1237), 1'b0, "cur read 1");
    mst_u.stop();
    mst_u.start();
    wb(8'h21, 1'b1, "cur read 2 ack");
    rb(pat(16'h1238), 1'b0, "cur read 2");
    mst_u.stop();
  endtask

  // Every setting of the select pins against both addresses
  task automatic t_addr_sel();
    logic e;
    wlog.delete();
    for (int i = 0; i < 4; i++)
    begin
      @(posedge ref_clk);
      #1;
      {sel_en, sel} = 2'(i);
      for (int j = 0; j < 2; j++)
      begin
        e = (j == 1) ~^ (i == 3);
        mst_u.start();
        wb(j == 1 ? 8'h30 : 8'h20, e, "select addr ack");
        wb(8'h55, e, "byte after addr");
        mst_u.stop();
      end
    end
    @(posedge ref_clk);
    #1;
    sel_en = 1'b0;
    sel = 1'b0;
    settle();
    chk16("select writes", 16'h0000, 16'(wlog.size()));
  endtask

  // Mismatch ignored until a restart addresses the slave
  task automatic t_mismatch();
    mst_u.start();
    wb(8'h30, 1'b0, "foreign addr nack");
    wb(8'h20, 1'b0, "ignored byte");
    mst_u.start();
    wb(8'h20, 1'b1, "restart addr ack");
    mst_u.stop();
  endtask

  // Programmed address replaces default and select, then cleared
  task automatic t_override();
    mst_u.start();
    wb(8'h20, 1'b1, "ovr addr ack");
    wb(8'h31, 1'b1, "ovr ptr high");
    wb(8'hfd, 1'b1, "ovr ptr low");
    wb(8'h44, 1'b1, "ovr data");
    mst_u.stop();
    @(posedge ref_clk);
    #1;
    sel_en = 1'b1;
    sel = 1'b1;
    mst_u.start();
    wb(8'h20, 1'b0, "old addr nack");
    mst_u.start();
    wb(8'h30, 1'b0, "select under ovr");
    mst_u.start();
    wb(8'h44, 1'b1, "new addr ack");
    wb(8'h31, 1'b1, "clr ptr high");
    wb(8'hfd, 1'b1, "clr ptr low");
    wb(8'h00, 1'b1, "clr data");
    mst_u.stop();
    @(posedge ref_clk);
    #1;
    sel_en = 1'b0;
    sel = 1'b0;
    mst_u.start();
    wb(8'h20, 1'b1, "default again");
    mst_u.stop();
  endtask

  // ============================================================
  // Main sequence
  initial
  begin
    sys_rst = 1'b1;
    sel_en = 1'b0;
    sel = 1'b0;
    rdata = 8'h00;
    n_fail = 0;
    compares = 0;
    cyc = 0;
    repeat (16) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    repeat (20) @(posedge ref_clk);
    #1;
    chk1("idle release", 1'b1, oe_n);
    t_write();
    t_rand_read();
    t_cur_read();
    t_addr_sel();
    t_mismatch();
    t_override();
    settle();
    end_of_test();
  end
endmodule

// ---- design/tws_map.svh ----
/*
  Constants of the two-wire register slave: slave addresses, the address
  override register and reset values of the link-side state.
  Assumes inclusion by bare name from the tws_slave design module.
*/
`ifndef TWS_MAP_SVH
`define TWS_MAP_SVH

// ============================================================
// Slave addresses (7-bit form of the 8-bit write address)
`define TWS_ADDR_DEF 7'h10
`define TWS_ADDR_ALT 7'h18

// ============================================================
// Address override register and the byte that carries the address
`define TWS_OVR_REG 16'h31fc
`define TWS_OVR_BYTE (`TWS_OVR_REG + 16'h0001)

// ============================================================
// Reset values and byte framing
`define TWS_PTR_RST 16'h0000
`define TWS_BYTE_RST 8'h00
`define TWS_LAST_BIT 3'h7

`endif

// ---- design/tws_pkg.sv ----
/*
  Types shared by the two-wire register slave: link state encoding and
  the register request that crosses from the link domain to the core.
  Assumes nothing of its surroundings.
*/
package tws_pkg;

  // ============================================================
  // Link engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK = 3'b010,
    ST_RX = 3'b011,
    ST_TX = 3'b100,
    ST_TACK = 3'b101,
    ST_SKIP = 3'b110
  } tws_state_t;

  // ============================================================
  // Register access request, held stable while its toggle crosses
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
  } tws_req_t;

endpackage

// ---- design/tws_slave.sv ----
/*
  Two-wire serial register slave. The bus engine runs on link_clk and
  oversamples the clock and data pins; register accesses cross to ref_clk
  and leave on a byte-wide register port.
  Assumes link_clk is free-running and at least ten times the bus clock,
  and that the register port answers a read on the cycle after its strobe.
*/
`timescale 1ns/1ns
`include "tws_map.svh"
module tws_slave
  import tws_pkg::*;
(
  // Core clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Link sampling clock
  input wire logic link_clk,
  // Bus pins
  input wire logic scl_in,
  input wire logic serial_data_line_in,
  output logic serial_data_line_out,
  output logic serial_data_line_oe_n,
  // Slave address select
  input wire logic slave_addr_sel_en,
  input wire logic slave_addr_sel,
  // Register port
  output logic [15:0] regp_addr_r,
  output logic [7:0] regp_wdata_r,
  output logic regp_wr_r,
  output logic regp_rd_r,
  input wire logic [7:0] regp_rdata
);

  // ============================================================
  // Link domain reset and pin sampling
  logic link_rst;
  logic [3:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic scl_q_r;
  logic sda_q_r;

  tws_sync2 #(.W(1)) u_rst_sync (
    .clk(link_clk),
    .rst(1'b0),
    .d(sys_rst),
    .q(link_rst)
  );

  // Pins track the wire through reset, so no false edge follows its release
  tws_sync2 #(.W(4)) u_pin_sync (
    .clk(link_clk),
    .rst(1'b0),
    .d({scl_in, serial_data_line_in, slave_addr_sel_en, slave_addr_sel}),
    .q(pins_s)
  );

  assign scl_s = pins_s[3];
  assign sda_s = pins_s[2];

  // History of the synchronised lines, idle-high after reset
  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end
    else
    begin
      scl_q_r <= scl_s;
      sda_q_r <= sda_s;
    end
  end

  // ============================================================
  // Bus events
  logic scl_high;
  logic start_ev;
  logic stop_ev;
  logic scl_rise;
  logic scl_fall;
  logic bus_idle;

  assign scl_high = scl_s & scl_q_r;
  assign start_ev = scl_high & sda_q_r & ~sda_s;
  assign stop_ev = scl_high & ~sda_q_r & sda_s;
  assign bus_idle = scl_s & sda_s;
  assign scl_rise = ~scl_q_r & scl_s;
  assign scl_fall = scl_q_r & ~scl_s;

  // ============================================================
  // Link engine state
  tws_state_t state_r, state_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic rw_r, rw_nxt;
  logic oe_n_nxt;
  logic [1:0] idx_r, idx_nxt;
  logic [15:0] ptr_r, ptr_nxt;
  logic [6:0] ovr_r, ovr_nxt;
  logic ovr_vld_r, ovr_vld_nxt;
  logic more_r, more_nxt;
  tws_req_t req_r, req_nxt;
  logic req_tgl_r, req_tgl_nxt;
  logic [7:0] rdbuf_r;
  logic [7:0] rdata_r; // Core side, read here only after its toggle lands
  logic ack_pulse;
  logic [7:0] rx_byte;
  logic [6:0] cur_addr;
  logic addr_hit;
  logic last_bit;

  // Pointer step, shared by the write and read paths
  function automatic logic [15:0] ptr_inc(input logic [15:0] p);
    ptr_inc = p + 16'h0001;
  endfunction

  // Read request for a given pointer
  function automatic tws_req_t rd_req(input logic [15:0] p);
    rd_req = '{addr: p, wdata: `TWS_BYTE_RST, wr: 1'b0};
  endfunction

  assign rx_byte = {sh_r[6:0], sda_s};
  assign last_bit = (cnt_r == `TWS_LAST_BIT);
  // Override wins, then the select strap, then the default
  assign cur_addr = ovr_vld_r ? ovr_r :
    ((pins_s[1] & pins_s[0]) ? `TWS_ADDR_ALT : `TWS_ADDR_DEF);
  assign addr_hit = (rx_byte[7:1] == cur_addr);

  // Next state of the bus engine
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    rw_nxt = rw_r;
    oe_n_nxt = serial_data_line_oe_n;
    idx_nxt = idx_r;
    ptr_nxt = ptr_r;
    ovr_nxt = ovr_r;
    ovr_vld_nxt = ovr_vld_r;
    more_nxt = more_r;
    req_nxt = req_r;
    req_tgl_nxt = req_tgl_r;
    if (stop_ev)
    begin
      state_nxt = ST_IDLE;
      oe_n_nxt = 1'b1;
    end
    else if (start_ev)
    begin
      state_nxt = ST_ADDR;
      cnt_nxt = 3'h0;
      idx_nxt = 2'h0;
      more_nxt = 1'b0;
      oe_n_nxt = 1'b1;
    end
    else
    begin
      case (state_r)
        ST_ADDR:
          if (scl_rise)
          begin
            sh_nxt = rx_byte;
            cnt_nxt = cnt_r + 3'h1;
            if (last_bit)
            begin
              rw_nxt = sda_s;
              if (addr_hit)
              begin
                state_nxt = ST_ACK;
                if (sda_s)
                begin
                  req_nxt = rd_req(ptr_r);
                  req_tgl_nxt = ~req_tgl_r;
                end
              end
              else
              begin
                state_nxt = ST_SKIP;
              end
            end
          end
        ST_ACK:
          if (scl_fall)
          begin
            cnt_nxt = 3'h0;
            if (serial_data_line_oe_n)
            begin
              oe_n_nxt = 1'b0;
            end
            else if (rw_r)
            begin
              sh_nxt = rdbuf_r;
              oe_n_nxt = rdbuf_r[7];
              state_nxt = ST_TX;
            end
            else
            begin
              oe_n_nxt = 1'b1;
              state_nxt = ST_RX;
            end
          end
        ST_RX:
          if (scl_rise)
          begin
            sh_nxt = rx_byte;
            cnt_nxt = cnt_r + 3'h1;
            if (last_bit)
            begin
              state_nxt = ST_ACK;
              case (idx_r)
                2'h0:
                begin
                  ptr_nxt = {rx_byte, ptr_r[7:0]};
                  idx_nxt = 2'h1;
                end
                2'h1:
                begin
                  ptr_nxt = {ptr_r[15:8], rx_byte};
                  idx_nxt = 2'h2;
                end
                default:
                begin
                  req_nxt = '{addr: ptr_r, wdata: rx_byte, wr: 1'b1};
                  req_tgl_nxt = ~req_tgl_r;
                  ptr_nxt = ptr_inc(ptr_r);
                  if (ptr_r == `TWS_OVR_BYTE)
                  begin
                    ovr_nxt = rx_byte[7:1];
                    ovr_vld_nxt = |rx_byte[7:1];
                  end
                end
              endcase
            end
          end
        ST_TX:
        begin
          if (scl_fall)
          begin
            sh_nxt = {sh_r[6:0], 1'b0};
            oe_n_nxt = sh_r[6];
          end
          if (scl_rise)
          begin
            cnt_nxt = cnt_r + 3'h1;
            if (last_bit)
            begin
              state_nxt = ST_TACK;
              ptr_nxt = ptr_inc(ptr_r);
              req_nxt = rd_req(ptr_inc(ptr_r));
              req_tgl_nxt = ~req_tgl_r;
            end
          end
        end
        ST_TACK:
        begin
          if (scl_fall)
          begin
            if (more_r)
            begin
              sh_nxt = rdbuf_r;
              oe_n_nxt = rdbuf_r[7];
              cnt_nxt = 3'h0;
              more_nxt = 1'b0;
              state_nxt = ST_TX;
            end
            else
            begin
              oe_n_nxt = 1'b1;
            end
          end
          if (scl_rise)
          begin
            if (!sda_s)
            begin
              more_nxt = 1'b1;
            end
            else
            begin
              state_nxt = ST_SKIP;
            end
          end
        end
        ST_SKIP, ST_IDLE:
          oe_n_nxt = 1'b1;
        default:
        begin
          state_nxt = ST_IDLE;
          oe_n_nxt = 1'b1;
        end
      endcase
    end
  end

  // Link engine registers
  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      state_r <= ST_IDLE;
      cnt_r <= 3'h0;
      sh_r <= `TWS_BYTE_RST;
      rw_r <= 1'b0;
      serial_data_line_oe_n <= 1'b1;
      idx_r <= 2'h0;
      ptr_r <= `TWS_PTR_RST;
      ovr_r <= 7'h00;
      ovr_vld_r <= 1'b0;
      more_r <= 1'b0;
      req_r <= '0;
      req_tgl_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      rw_r <= rw_nxt;
      serial_data_line_oe_n <= oe_n_nxt;
      idx_r <= idx_nxt;
      ptr_r <= ptr_nxt;
      ovr_r <= ovr_nxt;
      ovr_vld_r <= ovr_vld_nxt;
      more_r <= more_nxt;
      req_r <= req_nxt;
      req_tgl_r <= req_tgl_nxt;
    end
  end

  // Data pin is open drain: the output level is always low
  always_ff @(posedge link_clk)
  begin
    serial_data_line_out <= 1'b0;
  end

  // Read data returns by toggle; the core holds it until the next read
  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      rdbuf_r <= `TWS_BYTE_RST;
    end
    else if (ack_pulse)
    begin
      rdbuf_r <= rdata_r;
    end
  end

  // ============================================================
  // Core domain: register port
  logic req_pulse;
  logic rd_d_r;
  logic ack_tgl_r;

  tws_tgl_rx u_req_rx (
    .clk(ref_clk),
    .rst(sys_rst),
    .tgl(req_tgl_r),
    .pulse(req_pulse)
  );

  tws_tgl_rx u_ack_rx (
    .clk(link_clk),
    .rst(link_rst),
    .tgl(ack_tgl_r),
    .pulse(ack_pulse)
  );

  // Request fields are stable for many cycles around the toggle
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      regp_addr_r <= `TWS_PTR_RST;
      regp_wdata_r <= `TWS_BYTE_RST;
      regp_wr_r <= 1'b0;
      regp_rd_r <= 1'b0;
      rd_d_r <= 1'b0;
      rdata_r <= `TWS_BYTE_RST;
      ack_tgl_r <= 1'b0;
    end
    else
    begin
      if (req_pulse)
      begin
        regp_addr_r <= req_r.addr;
        regp_wdata_r <= req_r.wdata;
      end
      regp_wr_r <= req_pulse & req_r.wr;
      regp_rd_r <= req_pulse & ~req_r.wr;
      rd_d_r <= regp_rd_r;
      if (rd_d_r)
      begin
        rdata_r <= regp_rdata;
        ack_tgl_r <= ~ack_tgl_r;
      end
    end
  end

  // ============================================================
  // Checks
  property p_stop_idle;
    @(posedge link_clk) disable iff (link_rst)
    stop_ev |=> (state_r == ST_IDLE) && serial_data_line_oe_n;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop not honoured");

  property p_start_addr;
    @(posedge link_clk) disable iff (link_rst)
    (start_ev && !stop_ev) |=> (state_r == ST_ADDR) && (cnt_r == 3'h0);
  endproperty
  a_start_addr: assert property (p_start_addr) else $error("start not taken");

  property p_high_stable;
    @(posedge link_clk) disable iff (link_rst)
    (scl_high && !start_ev && !stop_ev) |=> $stable(serial_data_line_oe_n);
  endproperty
  a_high_stable: assert property (p_high_stable) else $error("data moved in clock high");

  property p_skip_quiet;
    @(posedge link_clk) disable iff (link_rst)
    (state_r == ST_SKIP) |-> serial_data_line_oe_n;
  endproperty
  a_skip_quiet: assert property (p_skip_quiet) else $error("driving while unselected");

  property p_addr_match;
    @(posedge link_clk) disable iff (link_rst)
    (state_r == ST_ADDR && scl_rise && last_bit && !start_ev && !stop_ev)
      |=> (state_r == (($past(addr_hit)) ? ST_ACK : ST_SKIP));
  endproperty
  a_addr_match: assert property (p_addr_match) else $error("address match wrong");

  property p_ack_low;
    @(posedge link_clk) disable iff (link_rst)
    (state_r == ST_ACK && scl_fall && serial_data_line_oe_n && !start_ev)
      |=> !serial_data_line_oe_n [*2];
  endproperty
  a_ack_low: assert property (p_ack_low) else $error("ack not driven");

  property p_ptr_step;
    @(posedge link_clk) disable iff (link_rst)
    (state_r == ST_TX && scl_rise && last_bit && !stop_ev && !start_ev)
      |=> ptr_r == ($past(ptr_r) + 16'h0001);
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer not stepped");

  property p_nack_end;
    @(posedge link_clk) disable iff (link_rst)
    (state_r == ST_TACK && scl_rise && sda_s && !stop_ev && !start_ev)
      |=> state_r == ST_SKIP ##1 serial_data_line_oe_n;
  endproperty
  a_nack_end: assert property (p_nack_end) else $error("nack ignored");

  property p_addr_default;
    @(posedge link_clk) disable iff (link_rst)
    (state_r == ST_ADDR && scl_rise && last_bit && !start_ev && !stop_ev && !ovr_vld_r
      && !(pins_s[1] && pins_s[0]) && rx_byte[7:1] == `TWS_ADDR_DEF) |=> state_r == ST_ACK;
  endproperty
  a_addr_default: assert property (p_addr_default) else $error("bad default address");

  property p_rd_answer;
    @(posedge ref_clk) disable iff (sys_rst)
    regp_rd_r |=> ##1 (ack_tgl_r != $past(ack_tgl_r, 2));
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not returned");

  c_write: cover property (@(posedge link_clk) state_r == ST_RX && idx_r == 2'h2 && stop_ev);
  c_read_more: cover property (@(posedge link_clk) state_r == ST_TACK && more_r);
  c_restart: cover property (@(posedge link_clk) start_ev && state_r == ST_RX);
  c_idle: cover property (@(posedge link_clk) bus_idle && state_r == ST_IDLE);

endmodule

// ---- design/tws_sync2.sv ----
/*
  Two flip-flop level synchroniser, one bit per lane.
  Assumes a level input that may change at any time relative to clk.
*/
`timescale 1ns/1ns
module tws_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Level in and out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  // First stage is read only by the second
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

// ---- design/tws_tgl_rx.sv ----
/*
  Receiving end of a toggle event crossing: synchronises the toggle and
  gives a one-cycle pulse for each change.
  Assumes the sender holds each toggle level for at least three clk edges.
*/
`timescale 1ns/1ns
module tws_tgl_rx (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Toggle in, pulse out
  input wire logic tgl,
  output logic pulse
);

  logic meta_r;
  logic s1_r;
  logic s2_r;

  // Synchroniser plus history flop for the edge
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_r <= 1'b0;
      s1_r <= 1'b0;
      s2_r <= 1'b0;
    end
    else
    begin
      meta_r <= tgl;
      s1_r <= meta_r;
      s2_r <= s1_r;
    end
  end

  assign pulse = s1_r ^ s2_r;

endmodule
